// ===== src/servo_option_params.svh
`ifndef SERVO_OPTION_PARAMS_SVH
`define SERVO_OPTION_PARAMS_SVH

// Register byte offsets
`define ADR_CFG 8'h00
`define ADR_CMD 8'h04
`define ADR_FRAME_A 8'h08
`define ADR_FRAME_B 8'h0c
`define ADR_OUTASN 8'h14
`define ADR_STATUS 8'h18
`define ADR_SETTINGS 8'h1c
`define ADR_RESP0 8'h20
`define ADR_RESP1 8'h24
`define ADR_RESP2 8'h28
`define ADR_RESP3 8'h2c
`define ADR_ALLOC_HI 2'h1

// Command register bits
`define CMD_CONFIG 0
`define CMD_FRAME 1
`define CMD_ENC_ON 2
`define CMD_REF_SET 3

// Status register bits
`define ST_SUPPLY 0
`define ST_POS_UNDEF 1
`define ST_REF_VALID 2
`define ST_WARN 3
`define ST_PHASE_ERR 4
`define ST_BUSY 5
`define ST_RESP_RDY 6
`define ST_CODE_LSB 16

// Frame codes and values
`define CMD_ENC_OFF 8'h24
`define WARN_CODE 12'h95a
`define PHASE_TWO 2'h2
`define PHASE_THREE 2'h3
`define ACC_FORBIDDEN 2'h3
`define ALLOC_CUSTOM 1'h1

// Allocation word: [3:0] lowest bit position, [4] allocated
`define ALLOC_ON_BIT 4
`define NUM_FUNC 9
`define F_ACC 0
`define F_GAIN 1
`define F_SPD 2
`define F_INT 3
`define F_FWD 4
`define F_REV 5
`define F_LATCH 6
`define F_BANK 7
`define F_OUT 8
`define DEF_POS_ACC 4'h3
`define DEF_POS_GAIN 4'h8
`define DEF_POS_SPD 4'hc
`define DEF_POS_INT 4'hd
`define DEF_POS_FWD 4'he
`define DEF_POS_REV 4'hf

// Timing
`define CLK_HZ 25000000
`define ENC_OFF_MAX_MS 2000
`define ENC_OFF_CYCLES ((`ENC_OFF_MAX_MS) * ((`CLK_HZ) / 1000))

`endif

// ===== src/servo_option_pkg.sv
package servo_option_pkg;

    typedef logic [15:0] option_word_t;

    typedef enum logic [0:0]
    {
        ENC_IDLE = 1'b0,
        ENC_WAIT = 1'b1
    } enc_state_e;

endpackage

// ===== src/option_field_pick.sv
`timescale 1ns/1ps
`include "servo_option_params.svh"

module option_field_pick
    import servo_option_pkg::*;
#(
    parameter int W = 1
)
(
    // Option word and allocation
    input option_word_t option_word,
    input logic [3:0] pos,
    input logic allocated,
    // Extracted field
    output logic [W-1:0] value
);

    option_word_t shifted;

    always_comb
    begin
        shifted = option_word >> pos;
        // Bits past D15 shift in as zero
        value = allocated ? shifted[W-1:0] : '0;
    end

endmodule

// ===== src/servo_option_top.sv
// Chosen here: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`include "servo_option_params.svh"

module servo_option_top
    import servo_option_pkg::*;
#(
    parameter int unsigned ENC_OFF_CYCLES = `ENC_OFF_CYCLES
)
(
    // Clock and reset
    input logic clk,
    input logic rst,
    // Wishbone slave
    input logic wb_cyc,
    input logic wb_stb,
    input logic wb_we,
    input logic [7:0] wb_adr,
    input logic [3:0] wb_sel,
    input logic [31:0] wb_wdat,
    output logic [31:0] wb_rdat,
    output logic wb_ack,
    // Drive state
    input logic [1:0] comm_phase,
    input logic servo_energized,
    input logic abs_encoder_used,
    input logic [7:0] alarm_code,
    input logic [15:0] status_word,
    input logic [31:0] first_monitor_value,
    input logic [31:0] second_monitor_value,
    input logic [15:0] input_monitor_word,
    input logic latch_signal_in,
    // Decoded control settings
    output logic [1:0] accel_filter_select,
    output logic gain_set_second,
    output logic speed_loop_prop_only,
    output logic position_integral_clear,
    output logic forward_torque_limit_on,
    output logic reverse_torque_limit_on,
    output logic latch_input_block,
    output logic latch_event,
    output logic [3:0] accel_param_bank,
    output logic general_output_one,
    output logic general_output_two,
    output logic general_output_three,
    output logic [7:0] monitor_selection,
    // Encoder supply and reference state
    output logic encoder_supply_on,
    output logic position_data_undefined,
    output logic reference_point_valid,
    output logic origin_point_valid,
    output logic soft_limit_valid,
    output logic command_warning
);

    logic ack_r;
    logic [31:0] rdat_r;
    logic alloc_en_r;
    logic [3:0] alloc_pos_r [`NUM_FUNC];
    logic [`NUM_FUNC-1:0] alloc_on_r;
    logic [3:0] act_pos_r [`NUM_FUNC];
    logic [`NUM_FUNC-1:0] act_on_r;
    logic [31:0] frame_a_r;
    logic [7:0] frame_b_r;
    logic [23:0] out_asn_r;
    enc_state_e enc_state_r;
    logic [31:0] enc_cnt_r;
    logic supply_r;
    logic pos_undef_r;
    logic [2:0] refs_valid_r;
    logic warn_r;
    logic phase_err_r;
    logic resp_rdy_r;
    logic [31:0] resp_r [4];
    logic [7:0] reply_wdt_r;
    logic [7:0] mon_sel_r;
    logic [1:0] acc_r;
    logic gain_r;
    logic spd_r;
    logic int_r;
    logic fwd_r;
    logic rev_r;
    logic latch_blk_r;
    logic latch_ev_r;
    logic [3:0] bank_r;
    logic [2:0] gen_out_r;
    logic [31:0] rd_mux;

    logic wr_en;
    logic wr_alloc;
    logic [3:0] alloc_idx;
    logic cmd_wr;
    logic config_go;
    logic frame_go;
    logic accept_frame;
    logic is_enc_off;
    logic phase_ok;
    logic enc_phase_bad;
    logic enc_warn;
    logic enc_exec;
    logic opt_exec;
    logic wait_done;
    logic resp_go;
    option_word_t frame_opt;
    logic [1:0] acc_v;
    logic [1:0] gain_v;
    logic spd_v;
    logic int_v;
    logic fwd_v;
    logic rev_v;
    logic latch_v;
    logic [3:0] bank_v;
    logic [2:0] out_v;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
            begin
                m[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return m;
    endfunction

    function automatic logic [4:0] def_alloc(input int idx);
        case (idx)
            `F_ACC: def_alloc = {1'b1, `DEF_POS_ACC};
            `F_GAIN: def_alloc = {1'b1, `DEF_POS_GAIN};
            `F_SPD: def_alloc = {1'b1, `DEF_POS_SPD};
            `F_INT: def_alloc = {1'b1, `DEF_POS_INT};
            `F_FWD: def_alloc = {1'b1, `DEF_POS_FWD};
            `F_REV: def_alloc = {1'b1, `DEF_POS_REV};
            default: def_alloc = 5'h00;
        endcase
    endfunction

    // One access per request; ack drops the cycle after it rose
    assign wr_en = wb_cyc && wb_stb && wb_we && !ack_r;
    assign alloc_idx = wb_adr[5:2];
    assign wr_alloc = wr_en && (wb_adr[7:6] == `ADR_ALLOC_HI) && (alloc_idx < 4'(`NUM_FUNC));
    assign cmd_wr = wr_en && (wb_adr == `ADR_CMD) && wb_sel[0];
    assign config_go = cmd_wr && wb_wdat[`CMD_CONFIG];
    assign frame_go = cmd_wr && wb_wdat[`CMD_FRAME];
    assign frame_opt = frame_a_r[23:8];
    assign is_enc_off = frame_a_r[7:0] == `CMD_ENC_OFF;
    assign phase_ok = (comm_phase == `PHASE_TWO) || (comm_phase == `PHASE_THREE);
    // Frames arriving during the supply-off wait are dropped, not queued
    assign accept_frame = frame_go && (enc_state_r == ENC_IDLE);
    assign enc_phase_bad = accept_frame && is_enc_off && !phase_ok;
    assign enc_warn = accept_frame && is_enc_off && phase_ok && servo_energized;
    assign enc_exec = accept_frame && is_enc_off && phase_ok && !servo_energized;
    assign opt_exec = accept_frame && !is_enc_off;
    assign wait_done = (enc_state_r == ENC_WAIT) && (enc_cnt_r == 32'(ENC_OFF_CYCLES - 1));
    assign resp_go = opt_exec || enc_phase_bad || enc_warn || wait_done;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ack_r <= 1'b0;
            rdat_r <= 32'h0;
        end
        else
        begin
            ack_r <= wb_cyc && wb_stb && !ack_r;
            rdat_r <= (wb_cyc && wb_stb && !wb_we && !ack_r) ? rd_mux : 32'h0;
        end
    end

    always_comb
    begin
        rd_mux = 32'h0;
        case (wb_adr)
            `ADR_CFG: rd_mux = {31'h0, alloc_en_r};
            `ADR_FRAME_A: rd_mux = frame_a_r;
            `ADR_FRAME_B: rd_mux = {24'h0, frame_b_r};
            `ADR_OUTASN: rd_mux = {8'h0, out_asn_r};
            `ADR_STATUS:
            begin
                rd_mux[`ST_SUPPLY] = supply_r;
                rd_mux[`ST_POS_UNDEF] = pos_undef_r;
                rd_mux[`ST_REF_VALID] = &refs_valid_r;
                rd_mux[`ST_WARN] = warn_r;
                rd_mux[`ST_PHASE_ERR] = phase_err_r;
                rd_mux[`ST_BUSY] = enc_state_r == ENC_WAIT;
                rd_mux[`ST_RESP_RDY] = resp_rdy_r;
                rd_mux[`ST_CODE_LSB +: 12] = warn_r ? `WARN_CODE : 12'h000;
            end
            `ADR_SETTINGS: rd_mux = {6'h0, gen_out_r, bank_r, latch_blk_r, rev_r, fwd_r,
                                     int_r, spd_r, 5'h0, gain_r, 6'h0, acc_r};
            `ADR_RESP0: rd_mux = resp_r[0];
            `ADR_RESP1: rd_mux = resp_r[1];
            `ADR_RESP2: rd_mux = resp_r[2];
            `ADR_RESP3: rd_mux = resp_r[3];
            default:
            begin
                if ((wb_adr[7:6] == `ADR_ALLOC_HI) && (alloc_idx < 4'(`NUM_FUNC)))
                begin
                    rd_mux = {27'h0, alloc_on_r[alloc_idx], alloc_pos_r[alloc_idx]};
                end
            end
        endcase
    end

    // Pending allocation; only config with custom allocation enabled makes it live, reset clears it to all unallocated
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            alloc_en_r <= 1'b0;
            alloc_on_r <= '0;
            out_asn_r <= 24'h0;
            for (int i = 0; i < `NUM_FUNC; i++)
            begin
                alloc_pos_r[i] <= 4'h0;
            end
        end
        else
        begin
            if (wr_en && (wb_adr == `ADR_CFG) && wb_sel[0])
            begin
                alloc_en_r <= wb_wdat[0];
            end
            if (wr_en && (wb_adr == `ADR_OUTASN))
            begin
                out_asn_r <= 24'(merge({8'h0, out_asn_r}, wb_wdat, wb_sel));
            end
            if (wr_alloc && wb_sel[0])
            begin
                alloc_pos_r[alloc_idx] <= wb_wdat[3:0];
                alloc_on_r[alloc_idx] <= wb_wdat[`ALLOC_ON_BIT];
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < `NUM_FUNC; i++)
            begin
                {act_on_r[i], act_pos_r[i]} <= def_alloc(i);
            end
        end
        else if (config_go)
        begin
            for (int i = 0; i < `NUM_FUNC; i++)
            begin
                if (alloc_en_r == `ALLOC_CUSTOM)
                begin
                    act_pos_r[i] <= alloc_pos_r[i];
                    act_on_r[i] <= alloc_on_r[i];
                end
                else
                begin
                    {act_on_r[i], act_pos_r[i]} <= def_alloc(i);
                end
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            frame_a_r <= 32'h0;
            frame_b_r <= 8'h0;
        end
        else
        begin
            if (wr_en && (wb_adr == `ADR_FRAME_A))
            begin
                frame_a_r <= merge(frame_a_r, wb_wdat, wb_sel);
            end
            if (wr_en && (wb_adr == `ADR_FRAME_B) && wb_sel[0])
            begin
                frame_b_r <= wb_wdat[7:0];
            end
        end
    end

    // Overlapping positions are the host's problem: each picker reads alone
    option_field_pick #(.W(2)) u_acc (.option_word(frame_opt), .pos(act_pos_r[`F_ACC]),
        .allocated(act_on_r[`F_ACC]), .value(acc_v));
    option_field_pick #(.W(2)) u_gain (.option_word(frame_opt), .pos(act_pos_r[`F_GAIN]),
        .allocated(act_on_r[`F_GAIN]), .value(gain_v));
    option_field_pick #(.W(1)) u_spd (.option_word(frame_opt), .pos(act_pos_r[`F_SPD]),
        .allocated(act_on_r[`F_SPD]), .value(spd_v));
    option_field_pick #(.W(1)) u_int (.option_word(frame_opt), .pos(act_pos_r[`F_INT]),
        .allocated(act_on_r[`F_INT]), .value(int_v));
    option_field_pick #(.W(1)) u_fwd (.option_word(frame_opt), .pos(act_pos_r[`F_FWD]),
        .allocated(act_on_r[`F_FWD]), .value(fwd_v));
    option_field_pick #(.W(1)) u_rev (.option_word(frame_opt), .pos(act_pos_r[`F_REV]),
        .allocated(act_on_r[`F_REV]), .value(rev_v));
    option_field_pick #(.W(1)) u_latch (.option_word(frame_opt), .pos(act_pos_r[`F_LATCH]),
        .allocated(act_on_r[`F_LATCH]), .value(latch_v));
    option_field_pick #(.W(4)) u_bank (.option_word(frame_opt), .pos(act_pos_r[`F_BANK]),
        .allocated(act_on_r[`F_BANK]), .value(bank_v));
    option_field_pick #(.W(3)) u_out (.option_word(frame_opt), .pos(act_pos_r[`F_OUT]),
        .allocated(act_on_r[`F_OUT]), .value(out_v));

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            acc_r <= 2'h0;
            gain_r <= 1'b0;
            spd_r <= 1'b0;
            int_r <= 1'b0;
            fwd_r <= 1'b0;
            rev_r <= 1'b0;
            latch_blk_r <= 1'b0;
            bank_r <= 4'h0;
            gen_out_r <= 3'h0;
        end
        else if (opt_exec)
        begin
            // Forbidden filter code keeps the running filter
            if (acc_v != `ACC_FORBIDDEN)
            begin
                acc_r <= acc_v;
            end
            if (!gain_v[1])
            begin
                gain_r <= gain_v[0];
            end
            spd_r <= spd_v;
            int_r <= int_v;
            fwd_r <= fwd_v;
            rev_r <= rev_v;
            latch_blk_r <= latch_v;
            bank_r <= bank_v;
            gen_out_r <= (out_asn_r == 24'h0) ? out_v : 3'h0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            latch_ev_r <= 1'b0;
        end
        else
        begin
            latch_ev_r <= latch_signal_in && !latch_blk_r;
        end
    end

    // Supply-off: switch off at once, report after the settle time
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            enc_state_r <= ENC_IDLE;
            enc_cnt_r <= 32'h0;
        end
        else
        begin
            case (enc_state_r)
                ENC_IDLE:
                begin
                    enc_cnt_r <= 32'h0;
                    if (enc_exec)
                    begin
                        enc_state_r <= ENC_WAIT;
                    end
                end
                ENC_WAIT:
                begin
                    enc_cnt_r <= enc_cnt_r + 32'h1;
                    if (wait_done)
                    begin
                        enc_state_r <= ENC_IDLE;
                    end
                end
                default:
                begin
                    enc_state_r <= ENC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            supply_r <= 1'b1;
            pos_undef_r <= 1'b0;
            refs_valid_r <= 3'h0;
        end
        else if (enc_exec)
        begin
            supply_r <= 1'b0;
            pos_undef_r <= abs_encoder_used;
            refs_valid_r <= 3'h0;
        end
        else if (cmd_wr)
        begin
            if (wb_wdat[`CMD_ENC_ON])
            begin
                supply_r <= 1'b1;
                pos_undef_r <= 1'b0;
            end
            if (wb_wdat[`CMD_REF_SET] && supply_r)
            begin
                refs_valid_r <= 3'h7;
            end
        end
    end

    // Sticky flags: write one clears warn and phase error, a new event wins; response ready clears only when an accepted frame starts the supply-off wait
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            warn_r <= 1'b0;
            phase_err_r <= 1'b0;
            resp_rdy_r <= 1'b0;
        end
        else
        begin
            if (enc_warn)
            begin
                warn_r <= 1'b1;
            end
            else if (wr_en && (wb_adr == `ADR_STATUS) && wb_sel[0] && wb_wdat[`ST_WARN])
            begin
                warn_r <= 1'b0;
            end
            if (enc_phase_bad)
            begin
                phase_err_r <= 1'b1;
            end
            else if (wr_en && (wb_adr == `ADR_STATUS) && wb_sel[0] && wb_wdat[`ST_PHASE_ERR])
            begin
                phase_err_r <= 1'b0;
            end
            if (resp_go)
            begin
                resp_rdy_r <= 1'b1;
            end
            else if (accept_frame)
            begin
                resp_rdy_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mon_sel_r <= 8'h0;
            reply_wdt_r <= 8'h0;
            for (int i = 0; i < 4; i++)
            begin
                resp_r[i] <= 32'h0;
            end
        end
        else
        begin
            if (accept_frame)
            begin
                mon_sel_r <= frame_a_r[31:24];
            end
            if (resp_go)
            begin
                reply_wdt_r <= reply_wdt_r + 8'h1;
                resp_r[0] <= {status_word, alarm_code, frame_a_r[7:0]};
                resp_r[1] <= first_monitor_value;
                resp_r[2] <= second_monitor_value;
                resp_r[3] <= {reply_wdt_r + 8'h1, input_monitor_word, frame_a_r[31:24]};
            end
        end
    end

    assign wb_ack = ack_r;
    assign wb_rdat = rdat_r;
    assign accel_filter_select = acc_r;
    assign gain_set_second = gain_r;
    assign speed_loop_prop_only = spd_r;
    assign position_integral_clear = int_r;
    assign forward_torque_limit_on = fwd_r;
    assign reverse_torque_limit_on = rev_r;
    assign latch_input_block = latch_blk_r;
    assign latch_event = latch_ev_r;
    assign accel_param_bank = bank_r;
    assign general_output_one = gen_out_r[0];
    assign general_output_two = gen_out_r[1];
    assign general_output_three = gen_out_r[2];
    assign monitor_selection = mon_sel_r;
    assign encoder_supply_on = supply_r;
    assign position_data_undefined = pos_undef_r;
    assign reference_point_valid = refs_valid_r[0];
    assign origin_point_valid = refs_valid_r[1];
    assign soft_limit_valid = refs_valid_r[2];
    assign command_warning = warn_r;

endmodule

// ===== verif/servo_option_sva.sv
`timescale 1ns/1ps
module servo_option_sva
(
    // Clock, reset, bus
    input logic clk,
    input logic rst,
    input logic wb_cyc,
    input logic wb_stb,
    input logic wb_ack,
    // Drive state
    input logic [1:0] comm_phase,
    input logic servo_energized,
    input logic abs_encoder_used,
    input logic latch_signal_in,
    // Watched outputs
    input logic [1:0] accel_filter_select,
    input logic latch_input_block,
    input logic latch_event,
    input logic encoder_supply_on,
    input logic position_data_undefined,
    input logic reference_point_valid,
    input logic origin_point_valid,
    input logic soft_limit_valid
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    AST_ACK: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack)
        else $error("ack late");
    AST_OFF_ON_ACK: assert property ($fell(encoder_supply_on) |-> wb_ack)
        else $error("supply off without command");
    AST_SERVO_ON: assert property (servo_energized |=> !$fell(encoder_supply_on))
        else $error("supply off while servo on");
    AST_PHASE: assert property (!comm_phase[1] |=> !$fell(encoder_supply_on))
        else $error("supply off in wrong phase");
    AST_UNDEF: assert property ($fell(encoder_supply_on) |->
        position_data_undefined == $past(abs_encoder_used))
        else $error("position undefined flag wrong");
    AST_REFS: assert property (reference_point_valid == origin_point_valid &&
        origin_point_valid == soft_limit_valid)
        else $error("reference flags differ");
    AST_OFF_REFS: assert property (!encoder_supply_on |-> !reference_point_valid)
        else $error("reference valid with supply off");
    AST_ACC: assert property (accel_filter_select != 2'h3)
        else $error("forbidden filter value");
    AST_LATCH_BLK: assert property (latch_input_block |=> !latch_event)
        else $error("latch passed while blocked");
    AST_LATCH_EV: assert property (latch_signal_in && !latch_input_block |=> latch_event)
        else $error("latch lost");
endmodule

bind servo_option_top servo_option_sva i_servo_option_sva
(
    .clk, .rst, .wb_cyc, .wb_stb, .wb_ack, .comm_phase, .servo_energized,
    .abs_encoder_used, .latch_signal_in, .accel_filter_select, .latch_input_block,
    .latch_event, .encoder_supply_on, .position_data_undefined, .reference_point_valid,
    .origin_point_valid, .soft_limit_valid
);

// ===== verif/host_model.sv
`timescale 1ns/1ps
`include "servo_option_params.svh"
module host_model
(
    // Clock
    input logic clk,
    // Wishbone master
    output logic wb_cyc,
    output logic wb_stb,
    output logic wb_we,
    output logic [7:0] wb_adr,
    output logic [3:0] wb_sel,
    output logic [31:0] wb_wdat,
    input logic [31:0] wb_rdat,
    input logic wb_ack
);
    initial
    begin
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_adr = 8'h00;
        wb_sel = 4'h0;
        wb_wdat = 32'h0;
    end
    task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_sel <= 4'hf;
        wb_wdat <= d;
        do
            @(posedge clk);
        while (wb_ack !== 1'b1);
        q = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        // Released lines show junk, not a stale value
        wb_adr <= ~a;
        wb_wdat <= ~d;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        xfer(1'b0, a, 32'h0, q);
    endtask
    task automatic frame(input logic [7:0] code, input logic [15:0] w, input logic [7:0] ms);
        wr(`ADR_FRAME_A, {ms, w[15:8], w[7:0], code});
        wr(`ADR_CMD, 32'h2);
    endtask
endmodule

// ===== verif/servo_option_field_and_encoder_off_bench.sv
`timescale 1ns/1ps
`include "servo_option_params.svh"
module servo_option_field_and_encoder_off_bench;
    logic clk, rst, wb_cyc, wb_stb, wb_we, wb_ack, servo_energized, abs_encoder_used;
    logic latch_signal_in, gain_set_second, speed_loop_prop_only, position_integral_clear;
    logic forward_torque_limit_on, reverse_torque_limit_on, latch_input_block, latch_event;
    logic general_output_one, general_output_two, general_output_three, encoder_supply_on;
    logic position_data_undefined, reference_point_valid, origin_point_valid;
    logic soft_limit_valid, command_warning;
    logic [1:0] comm_phase, accel_filter_select;
    logic [3:0] wb_sel, accel_param_bank;
    logic [7:0] wb_adr, alarm_code, monitor_selection;
    logic [15:0] status_word, input_monitor_word;
    logic [31:0] wb_wdat, wb_rdat, first_monitor_value, second_monitor_value, r;
    int n_fail, n_compared;
    // Short busy count keeps the run small
    servo_option_top #(.ENC_OFF_CYCLES(4)) i_servo_option_top
    (
        .clk, .rst, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_wdat, .wb_rdat, .wb_ack,
        .comm_phase, .servo_energized, .abs_encoder_used, .alarm_code, .status_word,
        .first_monitor_value, .second_monitor_value, .input_monitor_word, .latch_signal_in,
        .accel_filter_select, .gain_set_second, .speed_loop_prop_only,
        .position_integral_clear, .forward_torque_limit_on, .reverse_torque_limit_on,
        .latch_input_block, .latch_event, .accel_param_bank, .general_output_one,
        .general_output_two, .general_output_three, .monitor_selection, .encoder_supply_on,
        .position_data_undefined, .reference_point_valid, .origin_point_valid,
        .soft_limit_valid, .command_warning
    );
    host_model i_host_model
    (
        .clk, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_wdat, .wb_rdat, .wb_ack
    );
    function automatic logic [31:0] outs();
        return {17'h0, general_output_three, general_output_two, general_output_one,
            accel_param_bank, latch_input_block, reverse_torque_limit_on,
            forward_torque_limit_on, position_integral_clear, speed_loop_prop_only,
            gain_set_second, accel_filter_select};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic print_verdict();
        if (n_fail == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic t_reset();
        chk("rst supply", 32'h1, encoder_supply_on);
        chk("rst refs", 32'h0, reference_point_valid);
        chk("rst warn", 32'h0, command_warning);
        chk("rst set", 32'h0, outs());
        i_host_model.rd(8'h80, r);
        chk("unmapped", 32'h0, r);
        i_host_model.rd(`ADR_CMD, r);
        chk("cmd read", 32'h0, r);
        chk("latch open", 32'h1, latch_event);
    endtask
    task automatic t_option();
        logic [15:0] w[4] = '{16'hf108, 16'h0218, 16'h2010, 16'h0300};
        logic [31:0] e[4] = '{32'h7d, 32'h05, 32'h12, 32'h00};
        for (int i = 0; i < 4; i++)
        begin
            i_host_model.frame(8'h31, w[i], 8'h00);
            chk("settings", e[i], outs());
        end
    endtask
    task automatic t_custom();
        logic [4:0] a[9] = '{5'h0, 5'h0, 5'h0, 5'h0, 5'h0, 5'h0, 5'h10, 5'h11, 5'h15};
        i_host_model.wr(`ADR_CFG, 32'h1);
        for (int i = 0; i < 9; i++)
            i_host_model.wr(8'h40 + 8'(4 * i), {27'h0, a[i]});
        i_host_model.frame(8'h31, 16'hf108, 8'h00);
        chk("pending", 32'h7d, outs());
        i_host_model.wr(`ADR_CMD, 32'h1);
        i_host_model.frame(8'h31, 16'h80bf, 8'h00);
        chk("custom", 32'h5f80, outs());
        i_host_model.rd(`ADR_SETTINGS, r);
        chk("setreg", 32'h2fc0000, r);
        @(negedge clk);
        chk("latch blk", 32'h0, latch_event);
        i_host_model.wr(`ADR_OUTASN, 32'h100);
        i_host_model.frame(8'h31, 16'h80bf, 8'h00);
        chk("outasn", 32'h0f80, outs());
    endtask
    task automatic t_enc();
        i_host_model.wr(`ADR_CMD, 32'h8);
        chk("refs set", 32'h1, origin_point_valid);
        comm_phase <= 2'h1;
        i_host_model.frame(`CMD_ENC_OFF, 16'h0, 8'h00);
        i_host_model.rd(`ADR_STATUS, r);
        chk("phase err", 32'h1, r[4]);
        chk("phase sup", 32'h1, encoder_supply_on);
        comm_phase <= 2'h2;
        servo_energized <= 1'b1;
        i_host_model.frame(`CMD_ENC_OFF, 16'h0, 8'h00);
        i_host_model.rd(`ADR_STATUS, r);
        chk("warn code", 32'h95a, r[27:16]);
        chk("warn sup", 32'h1, encoder_supply_on);
        i_host_model.wr(`ADR_STATUS, 32'h18);
        chk("w1c", 32'h0, command_warning);
        comm_phase <= 2'h3;
        servo_energized <= 1'b0;
        abs_encoder_used <= 1'b1;
        i_host_model.frame(`CMD_ENC_OFF, 16'h0, 8'h5a);
        chk("supply", 32'h0, encoder_supply_on);
        chk("undef", 32'h1, position_data_undefined);
        chk("refs", 32'h0, {reference_point_valid, origin_point_valid, soft_limit_valid});
        chk("monsel", 32'h5a, monitor_selection);
        do
            i_host_model.rd(`ADR_STATUS, r);
        while (r[5] !== 1'b0);
        chk("ready", 32'h1, r[6]);
        i_host_model.rd(`ADR_RESP0, r);
        chk("resp0", {status_word, alarm_code, 8'h24}, r);
        i_host_model.rd(`ADR_RESP1, r);
        chk("resp1", first_monitor_value, r);
        i_host_model.rd(`ADR_RESP3, r);
        chk("resp3", {8'ha, input_monitor_word, 8'h5a}, r);
        i_host_model.wr(`ADR_CMD, 32'h4);
        chk("supply on", 32'h1, {encoder_supply_on, position_data_undefined} == 2'b10);
    endtask
    initial
    begin
        clk = 1'b0;
        forever
            #20 clk = ~clk;
    end
    initial
    begin
        n_fail = 0;
        n_compared = 0;
        rst = 1'b1;
        comm_phase = 2'h2;
        servo_energized = 1'b0;
        abs_encoder_used = 1'b0;
        latch_signal_in = 1'b1;
        alarm_code = 8'h07;
        status_word = 16'h0c3e;
        first_monitor_value = 32'h1234abcd;
        second_monitor_value = 32'h5566aa99;
        input_monitor_word = 16'h00f0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_option();
        t_custom();
        t_enc();
        print_verdict();
    end
    // Whole run is well under two hundred cycles
    initial
    begin
        repeat (3000) @(posedge clk);
        n_fail++;
        print_verdict();
    end
endmodule
